// ---- rtl/lsd_params.svh ----
// Purpose: Constants for the LED sink driver shift/latch block
// Assumes: Included by its bare name from rtl/
// Notes:   Mode sequences are {strobe, blank_n} pairs, oldest pair in the top bits
`ifndef LSD_PARAMS_SVH
`define LSD_PARAMS_SVH

`define LSD_NUM_OUT      16
`define LSD_CODE_W       7
`define LSD_CODE_LSB     0
`define LSD_GAIN_STEPS   128
`define LSD_CODE_RESET   7'h40
`define LSD_HIST_W       10
`define LSD_ENTRY_PAT    10'h11D
`define LSD_EXIT_PAT     10'h115
`define LSD_BUF_DEPTH    2

`endif

// ---- rtl/lsd_pkg.sv ----
// Purpose: Types shared by the LED sink driver files
// Assumes: Nothing beyond the params header
// Notes:   Mode codes are one-hot
`include "lsd_params.svh"

package lsd_pkg;

    typedef logic [`LSD_NUM_OUT-1:0] lsd_word_t;
    typedef logic [`LSD_CODE_W-1:0]  lsd_code_t;

    typedef enum logic [1:0]
    {
        LSD_NORMAL = 2'b01,
        LSD_ADJUST = 2'b10
    } lsd_mode_t;

endpackage

// ---- rtl/lsd_buf2.sv ----
// Purpose: Two-entry valid/ready buffer for gain codes
// Assumes: Both sides on core_clk; rst_n already synchronised
// Notes:   Full and empty are exact; no word is dropped on a stall
`timescale 1ns/1ns
`include "lsd_params.svh"

module lsd_buf2 #(
    parameter int WIDTH = `LSD_CODE_W
) (
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    import lsd_pkg::*;

    logic [WIDTH-1:0] mem_q [`LSD_BUF_DEPTH];
    logic [WIDTH-1:0] mem_d [`LSD_BUF_DEPTH];
    logic             wr_q;
    logic             wr_d;
    logic             rd_q;
    logic             rd_d;
    logic [1:0]       cnt_q;
    logic [1:0]       cnt_d;
    logic             push;
    logic             pop;

    assign in_ready  = (cnt_q != 2'h2);
    assign out_valid = (cnt_q != 2'h0);
    assign out_data  = mem_q[rd_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb
    begin
        mem_d = mem_q;
        wr_d  = wr_q;
        rd_d  = rd_q;
        cnt_d = cnt_q;
        if (push)
        begin
            mem_d[wr_q] = in_data;
            wr_d        = ~wr_q;
        end
        if (pop)
        begin
            rd_d = ~rd_q;
        end
        if (push && !pop)
        begin
            cnt_d = cnt_q + 2'h1;
        end
        else if (pop && !push)
        begin
            cnt_d = cnt_q - 2'h1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mem_q[0] <= '0;
            mem_q[1] <= '0;
            wr_q     <= 1'b0;
            rd_q     <= 1'b0;
            cnt_q    <= 2'h0;
        end
        else
        begin
            mem_q <= mem_d;
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end

endmodule

// ---- rtl/lsd_top.sv ----
// Purpose: Shift register, output latch, blanking and gain-code mode of a 16-sink driver
// Assumes: Pins are asynchronous to core_clk; serial clock well below core_clk / 4
// Notes:   Mode sequences and code placement come from the params header
//
// What this block does
// (R1) Shift serial_in into the shift register on each serial clock rising edge.
// (R2) Present the 16-bit parallel word on the sixteen sink outputs.
// (R3) Latch follows shift register while strobe high; holds while strobe low.
// (R4) Blank input low lets latched bits sink; high turns every output off.
// (R5) Serial output carries the bit leaving the last shift stage.
// (R6) A defined strobe/blank/clock sequence enters gain-adjust mode.
// (R7) A second defined sequence returns the block to normal mode.
// (R8) Controller shifts a 7-bit code in while gain-adjust mode is active.
// (R9) In gain-adjust mode a strobe pulse loads the configuration latch instead.
// (R10) Latched code selects gain 0.5 to 2 in 128 steps and stays in force.
// (R11) Blanking keeps working in both modes.
// (R12) Mode sequences and code position within the word are header constants.
`timescale 1ns/1ns
`include "lsd_params.svh"

module lsd_top (
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    input  wire logic              serial_clk,
    input  wire logic              serial_in,
    input  wire logic              strobe_adjust_one,
    input  wire logic              blank_n_adjust_two,
    input  wire logic              gain_ready,
    output lsd_pkg::lsd_word_t     sink_outputs,
    output logic                   serial_out,
    output lsd_pkg::lsd_code_t     gain_code,
    output logic                   adjust_mode
);
    import lsd_pkg::*;

    logic       rst_s1_q;
    logic       rst_s2_q;
    logic       rst_sync_n;
    logic [3:0] pin_s1_q;
    logic [3:0] pin_s2_q;
    logic       sclk_s3_q;
    logic       sclk_s;
    logic       din_s;
    logic       stb_s;
    logic       blank_s;
    logic       stb_s3_q;
    logic       rise;
    logic       stb_rise;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    assign rst_sync_n = rst_s2_q;

    // Two stages on the serial clock, data, strobe and blank pins; only stage two and later feed logic
    always_ff @(posedge core_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            pin_s1_q  <= 4'h8;
            pin_s2_q  <= 4'h8;
            sclk_s3_q <= 1'b0;
            stb_s3_q  <= 1'b0;
        end
        else
        begin
            pin_s1_q  <= {blank_n_adjust_two, strobe_adjust_one, serial_in, serial_clk};
            pin_s2_q  <= pin_s1_q;
            sclk_s3_q <= pin_s2_q[0];
            stb_s3_q  <= pin_s2_q[2];
        end
    end
    assign sclk_s   = pin_s2_q[0];
    assign din_s    = pin_s2_q[1];
    assign stb_s    = pin_s2_q[2];
    assign blank_s  = pin_s2_q[3];
    assign rise     = sclk_s && !sclk_s3_q;
    assign stb_rise = stb_s && !stb_s3_q;

    lsd_word_t                shift_q;
    lsd_word_t                shift_d;
    lsd_word_t                latch_q;
    lsd_word_t                latch_d;
    lsd_word_t                cfg_q;
    lsd_word_t                cfg_d;
    lsd_word_t                sink_q;
    lsd_word_t                sink_d;
    logic                     sout_q;
    logic                     sout_d;
    logic [`LSD_HIST_W-1:0]   hist_q;
    logic [`LSD_HIST_W-1:0]   hist_d;
    logic [`LSD_HIST_W-1:0]   hist_next;
    lsd_mode_t                mode_q;
    lsd_mode_t                mode_d;
    logic                     pend_q;
    logic                     pend_d;
    lsd_code_t                code_q;
    lsd_code_t                code_d;
    logic                     buf_in_ready;
    logic                     buf_out_valid;
    lsd_code_t                buf_out_data;
    logic                     adj;

    assign adj       = (mode_q == LSD_ADJUST);
    assign hist_next = {hist_q[`LSD_HIST_W-3:0], stb_s, blank_s};

    always_comb
    begin
        shift_d = shift_q;
        sout_d  = sout_q;
        hist_d  = hist_q;
        mode_d  = mode_q;
        latch_d = latch_q;
        cfg_d   = cfg_q;
        pend_d  = pend_q;
        if (rise)
        begin
            shift_d = {shift_q[`LSD_NUM_OUT-2:0], din_s};   // see (R1)
            sout_d  = shift_q[`LSD_NUM_OUT-2];              // see (R5)
            hist_d  = hist_next;
            case (mode_q)
                LSD_NORMAL:
                begin
                    if (hist_next == `LSD_ENTRY_PAT)        // see (R6) (R12)
                    begin
                        mode_d = LSD_ADJUST;
                        hist_d = '0;
                    end
                end
                LSD_ADJUST:
                begin
                    if (hist_next == `LSD_EXIT_PAT)         // see (R7) (R12)
                    begin
                        mode_d = LSD_NORMAL;
                        hist_d = '0;
                    end
                end
                default:
                begin
                    mode_d = LSD_NORMAL;
                end
            endcase
        end
        if (!adj && stb_s)
        begin
            latch_d = shift_q;                              // see (R3)
        end
        // Clear first so a new strobe in the push cycle still wins
        if (pend_q && buf_in_ready)
        begin
            pend_d = 1'b0;
        end
        if (adj && stb_rise)
        begin
            cfg_d  = shift_q;                               // see (R9) (R8)
            pend_d = 1'b1;
        end
    end

    always_comb
    begin
        // Blanking is honoured in both modes
        sink_d = blank_s ? '0 : latch_q;                    // see (R4) (R11) (R2)
        code_d = code_q;
        if (buf_out_valid)
        begin
            code_d = buf_out_data;                          // see (R10)
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            shift_q <= '0;
            sout_q  <= 1'b0;
            hist_q  <= '0;
            mode_q  <= LSD_NORMAL;
            latch_q <= '0;
            cfg_q   <= '0;
            pend_q  <= 1'b0;
            sink_q  <= '0;
            code_q  <= `LSD_CODE_RESET;
        end
        else
        begin
            shift_q <= shift_d;
            sout_q  <= sout_d;
            hist_q  <= hist_d;
            mode_q  <= mode_d;
            latch_q <= latch_d;
            cfg_q   <= cfg_d;
            pend_q  <= pend_d;
            sink_q  <= sink_d;
            code_q  <= code_d;
        end
    end

    // A stalled regulator backs up here; the latch keeps the newest word pending
    lsd_buf2 #(
        .WIDTH (`LSD_CODE_W)
    ) u_buf (
        .core_clk  (core_clk),
        .rst_n     (rst_sync_n),
        .in_valid  (pend_q),
        .in_ready  (buf_in_ready),
        .in_data   (cfg_q[`LSD_CODE_LSB +: `LSD_CODE_W]),
        .out_valid (buf_out_valid),
        .out_ready (gain_ready),
        .out_data  (buf_out_data)
    );

    assign sink_outputs = sink_q;
    assign serial_out   = sout_q;
    assign gain_code    = code_q;
    // One-hot adjust bit, so the port comes straight from the mode flop
    assign adjust_mode  = mode_q[1];

    property p_shift;
        @(posedge core_clk) disable iff (!rst_sync_n)
        rise |=> shift_q == {$past(shift_q[`LSD_NUM_OUT-2:0]), $past(din_s)};
    endproperty
    a_shift: assert property (p_shift) else $error("shift missed a bit"); // see (R1)

    property p_sout;
        @(posedge core_clk) disable iff (!rst_sync_n)
        rise |=> serial_out == shift_q[`LSD_NUM_OUT-1];
    endproperty
    a_sout: assert property (p_sout) else $error("serial out not last stage"); // see (R5)

    property p_pass;
        @(posedge core_clk) disable iff (!rst_sync_n)
        (!adj && stb_s) |=> latch_q == $past(shift_q);
    endproperty
    a_pass: assert property (p_pass) else $error("latch not transparent"); // see (R3)

    property p_hold;
        @(posedge core_clk) disable iff (!rst_sync_n)
        !stb_s |=> $stable(latch_q);
    endproperty
    a_hold: assert property (p_hold) else $error("latch moved while strobe low"); // see (R3)

    property p_blank;
        @(posedge core_clk) disable iff (!rst_sync_n)
        blank_s |=> sink_outputs == '0;
    endproperty
    a_blank: assert property (p_blank) else $error("outputs not blanked"); // see (R4)

    property p_drive;
        @(posedge core_clk) disable iff (!rst_sync_n)
        !blank_s |=> sink_outputs == $past(latch_q);
    endproperty
    a_drive: assert property (p_drive) else $error("outputs differ from latch"); // see (R11)

    property p_cfg;
        @(posedge core_clk) disable iff (!rst_sync_n)
        (adj && stb_rise) |=> cfg_q == $past(shift_q) && pend_q && $stable(latch_q);
    endproperty
    a_cfg: assert property (p_cfg) else $error("config write wrong"); // see (R9)

    property p_enter;
        @(posedge core_clk) disable iff (!rst_sync_n)
        (!adj && rise && hist_next == `LSD_ENTRY_PAT) |=> adj && hist_q == '0;
    endproperty
    a_enter: assert property (p_enter) else $error("adjust mode not entered"); // see (R6)

    property p_exit;
        @(posedge core_clk) disable iff (!rst_sync_n)
        (adj && rise && hist_next == `LSD_EXIT_PAT) |=> !adj;
    endproperty
    a_exit: assert property (p_exit) else $error("normal mode not resumed"); // see (R7)

    property p_code;
        @(posedge core_clk) disable iff (!rst_sync_n)
        (pend_q && buf_in_ready && !buf_out_valid && gain_ready) |=> ##1
            gain_code == $past(cfg_q[`LSD_CODE_LSB +: `LSD_CODE_W], 2);
    endproperty
    a_code: assert property (p_code) else $error("gain code not applied"); // see (R10)

    property p_code_keep;
        @(posedge core_clk) disable iff (!rst_sync_n)
        !buf_out_valid |=> $stable(gain_code);
    endproperty
    a_code_keep: assert property (p_code_keep) else $error("gain code drifted"); // see (R10)

    property p_adj_latch;
        @(posedge core_clk) disable iff (!rst_sync_n)
        adj |=> $stable(latch_q);
    endproperty
    a_adj_latch: assert property (p_adj_latch) else $error("latch moved in adjust"); // see (R9)

    property p_mode_step;
        @(posedge core_clk) disable iff (!rst_sync_n)
        !rise |=> $stable(mode_q);
    endproperty
    a_mode_step: assert property (p_mode_step) else $error("mode moved off a rise"); // see (R6)

endmodule

// ---- tb/lsd_ctrl_model.sv ----
// Purpose: Controller model driving serial data, serial clock, strobe and blank pins
// Assumes: Pins change on core_clk falling edges; one serial period is 9 core cycles
// Notes:   Serial clock idles low between frames; data pin inverts once hold has run out
`timescale 1ns/1ns

module lsd_ctrl_model (
    input  wire logic core_clk,
    output logic      serial_clk,
    output logic      serial_in,
    output logic      strobe_adjust_one,
    output logic      blank_n_adjust_two
);
    initial
    begin
        serial_clk = 1'b0;
        serial_in = 1'b0;
        strobe_adjust_one = 1'b0;
        blank_n_adjust_two = 1'b0;
    end

    // One serial clock period carrying a data bit and a {strobe, blank_n} pair
    task automatic pair(input logic d, input logic s, input logic b);
        @(negedge core_clk);
        serial_in = d;
        strobe_adjust_one = s;
        blank_n_adjust_two = b;
        repeat (4) @(negedge core_clk);
        serial_clk = 1'b1;
        repeat (4) @(negedge core_clk);
        serial_clk = 1'b0;
        // Hold has run out, so the stale bit must not linger
        serial_in = ~d;
    endtask

    // First bit sent lands in the top sink output
    task automatic send_word(input logic [15:0] w);
        for (int i = 15; i >= 0; i--)
        begin
            pair(w[i], 1'b0, blank_n_adjust_two);
        end
    endtask

    task automatic pulse();
        @(negedge core_clk);
        strobe_adjust_one = 1'b1;
        repeat (4) @(negedge core_clk);
        strobe_adjust_one = 1'b0;
        repeat (6) @(negedge core_clk);
    endtask

    task automatic set_blank(input logic b);
        @(negedge core_clk);
        blank_n_adjust_two = b;
        repeat (4) @(negedge core_clk);
    endtask

    // Data bits all ones so an all-ones shift register is left untouched
    task automatic enter_adjust();
        pair(1'b1, 1'b0, 1'b1);
        pair(1'b1, 1'b0, 1'b0);
        pair(1'b1, 1'b0, 1'b1);
        pair(1'b1, 1'b1, 1'b1);
        pair(1'b1, 1'b0, 1'b1);
    endtask

    task automatic leave_adjust();
        pair(1'b1, 1'b0, 1'b1);
        pair(1'b1, 1'b0, 1'b0);
        pair(1'b1, 1'b0, 1'b1);
        pair(1'b1, 1'b0, 1'b1);
        pair(1'b1, 1'b0, 1'b1);
    endtask
endmodule

// ---- tb/led_sink_driver_shift_latch_bench.sv ----
// Purpose: Self-checking bench for the LED sink driver shift/latch block
// Assumes: Controller model drives serial clock, data, strobe and blank pins; rst_n and gain_ready driven here
// Notes:   Gain code changes are logged so a stall can be shown to drop nothing
`timescale 1ns/1ns

module led_sink_driver_shift_latch_bench;
    import lsd_pkg::*;

    typedef struct packed
    {
        logic [15:0] word;
        logic        blank;
        logic [15:0] exp_sink;
        logic        exp_sout;
    } lsd_row_t;

    logic       core_clk;
    logic       rst_n;
    logic       gain_ready;
    logic       serial_clk;
    logic       serial_in;
    logic       strobe_adjust_one;
    logic       blank_n_adjust_two;
    lsd_word_t  sink_outputs;
    logic       serial_out;
    lsd_code_t  gain_code;
    logic       adjust_mode;
    lsd_code_t  last_code = 7'h40;
    lsd_code_t  seen[$];
    int         fails = 0;
    int         num_checks = 0;
    lsd_row_t   rows[4];
    lsd_code_t  codes[3];

`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin fails++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); end end

    always #10 core_clk = ~core_clk;

    lsd_ctrl_model u_ctrl (
        .core_clk           (core_clk),
        .serial_clk         (serial_clk),
        .serial_in          (serial_in),
        .strobe_adjust_one  (strobe_adjust_one),
        .blank_n_adjust_two (blank_n_adjust_two)
    );

    lsd_top u_dut (
        .core_clk           (core_clk),
        .rst_n              (rst_n),
        .serial_clk         (serial_clk),
        .serial_in          (serial_in),
        .strobe_adjust_one  (strobe_adjust_one),
        .blank_n_adjust_two (blank_n_adjust_two),
        .gain_ready         (gain_ready),
        .sink_outputs       (sink_outputs),
        .serial_out         (serial_out),
        .gain_code          (gain_code),
        .adjust_mode        (adjust_mode)
    );

    always @(posedge core_clk)
    begin
        if (gain_code !== last_code)
        begin
            seen.push_back(gain_code);
            last_code = gain_code;
        end
    end

    task automatic wrap_up();
        if (fails == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic write_code(input lsd_code_t c);
        u_ctrl.send_word({9'h000, c});
        u_ctrl.pulse();
    endtask

    initial
    begin
        #500000;
        fails++;
        wrap_up();
    end

    initial
    begin
        core_clk = 1'b0;
        rst_n = 1'b0;
        gain_ready = 1'b1;
        rows[0] = '{16'hA55A, 1'b0, 16'hA55A, 1'b1};
        rows[1] = '{16'h0001, 1'b0, 16'h0001, 1'b0};
        rows[2] = '{16'hFFFF, 1'b1, 16'h0000, 1'b1};
        rows[3] = '{16'h8000, 1'b0, 16'h8000, 1'b1};
        codes = '{7'h2A, 7'h7F, 7'h00};
        repeat (6) @(negedge core_clk);
        `CHK(sink_outputs, 16'h0000)
        `CHK(gain_code, 7'h40)
        `CHK(adjust_mode, 1'b0)
        rst_n = 1'b1;
        repeat (6) @(negedge core_clk);
        foreach (rows[i])
        begin
            u_ctrl.set_blank(rows[i].blank);
            u_ctrl.send_word(rows[i].word);
            u_ctrl.pulse();
            `CHK(sink_outputs, rows[i].exp_sink)
            `CHK(serial_out, rows[i].exp_sout)
        end
        u_ctrl.set_blank(1'b0);
        u_ctrl.send_word(16'h1234);
        repeat (6) @(negedge core_clk);
        `CHK(sink_outputs, 16'h8000)
        `CHK(serial_out, 1'b0)
        // Shift register stays all ones through the entry sequence
        u_ctrl.send_word(16'hFFFF);
        u_ctrl.pulse();
        u_ctrl.enter_adjust();
        u_ctrl.set_blank(1'b0);
        repeat (4) @(negedge core_clk);
        `CHK(adjust_mode, 1'b1)
        `CHK(sink_outputs, 16'hFFFF)
        write_code(7'h15);
        `CHK(gain_code, 7'h15)
        `CHK(sink_outputs, 16'hFFFF)
        u_ctrl.set_blank(1'b1);
        `CHK(sink_outputs, 16'h0000)
        u_ctrl.set_blank(1'b0);
        `CHK(sink_outputs, 16'hFFFF)
        @(negedge core_clk);
        gain_ready = 1'b0;
        seen.delete();
        foreach (codes[i])
            write_code(codes[i]);
        @(negedge core_clk);
        gain_ready = 1'b1;
        repeat (10) @(negedge core_clk);
        `CHK(seen.size(), 3)
        foreach (codes[i])
            if (i < seen.size())
                `CHK(seen[i], codes[i])
        u_ctrl.leave_adjust();
        u_ctrl.set_blank(1'b0);
        repeat (4) @(negedge core_clk);
        `CHK(adjust_mode, 1'b0)
        `CHK(gain_code, 7'h00)
        u_ctrl.send_word(16'h0F0F);
        u_ctrl.pulse();
        `CHK(sink_outputs, 16'h0F0F)
        // Mid-run reset from adjust mode must fall back to defaults
        u_ctrl.enter_adjust();
        @(negedge core_clk);
        `CHK(adjust_mode, 1'b1)
        rst_n = 1'b0;
        @(negedge core_clk);
        `CHK(adjust_mode, 1'b0)
        `CHK(gain_code, 7'h40)
        `CHK(sink_outputs, 16'h0000)
        repeat (3) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (6) @(negedge core_clk);
        u_ctrl.set_blank(1'b0);
        u_ctrl.send_word(16'hC3A5);
        u_ctrl.pulse();
        `CHK(sink_outputs, 16'hC3A5)
        `CHK(serial_out, 1'b1)
        wrap_up();
    end
endmodule
